// file: inc/dpsf_regs.svh
// register offsets, field positions and reset values of the sram/fifo block
// assumes a 32-bit apb slave with 12-bit byte addresses, one word per register
`ifndef DPSF_REGS_SVH
`define DPSF_REGS_SVH
`define DPSF_CTRL_OFS      12'h000
`define DPSF_DEPTH_OFS     12'h004
`define DPSF_AE_OFS        12'h008
`define DPSF_AF_OFS        12'h00C
`define DPSF_STAT_OFS      12'h010
`define DPSF_IRQ_STAT_OFS  12'h014
`define DPSF_IRQ_MASK_OFS  12'h018
`define DPSF_CTRL_W        9
`define DPSF_CTRL_RST      9'h036
`define DPSF_DEPTH_RST     13'h0200
`define DPSF_AE_RST        13'h0004
`define DPSF_AF_RST        13'h01FC
`define DPSF_STAT_CNT_LSB  4
`define DPSF_MEM_WORDS     512
`define DPSF_TOTAL_BITS    4608
`define DPSF_EVT_FULL      0
`define DPSF_EVT_EMPTY     1
`define DPSF_EVT_OVER      2
`define DPSF_EVT_UNDER     3
`define DPSF_N_EVT         4
`endif

// file: inc/dpsf_pkg.sv
// types shared by the sram/fifo block
// assumes the control register layout of dpsf_regs.svh
package dpsf_pkg;
    // port shapes, narrowest first
    typedef enum logic [2:0] {WID_1, WID_2, WID_4, WID_9, WID_18} dpsf_width_t;
    // control register image, bit 8 down to bit 0
    typedef struct packed {
        logic        wos;   // show write data on read port
        logic        pipe;  // extra output stage
        dpsf_width_t rd_w;  // read port shape
        dpsf_width_t wr_w;  // write port shape, also fifo shape
        logic        fifo;  // fifo operation
    } dpsf_cfg_t;
    // word and bit position of one access
    typedef struct packed {
        logic [8:0] word;
        logic [2:0] off;
    } dpsf_loc_t;
    // fifo flag bundle
    typedef struct packed {
        logic af;
        logic ae;
        logic full;
        logic empty;
    } dpsf_flags_t;
endpackage : dpsf_pkg

// file: design/dpsf_top.sv
// dual-port sram block with built-in fifo control and apb configuration
// assumes every input is synchronous to CLOCK; user logic drives the ports
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "dpsf_regs.svh"
module dpsf_top
    import dpsf_pkg::*;
(
    input  wire logic        CLOCK,
    input  wire logic        NRST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        WR_SEL,
    input  wire logic        WR_EN,
    input  wire logic [11:0] WR_ADDR,
    input  wire logic [17:0] WR_DATA,
    input  wire logic        RD_SEL,
    input  wire logic        RD_EN,
    input  wire logic [11:0] RD_ADDR,
    output logic      [17:0] RD_DATA,
    input  wire logic        TP_LOAD_EN,
    input  wire logic [8:0]  TP_LOAD_ADDR,
    input  wire logic [8:0]  TP_LOAD_DATA,
    output logic             EMPTY,
    output logic             FULL,
    output logic             ALMOST_EMPTY,
    output logic             ALMOST_FULL,
    output logic             IRQ
);

    // storage: 512 words of 9 bits
    logic [8:0]  mem [0:`DPSF_MEM_WORDS-1];
    // configuration
    logic [`DPSF_CTRL_W-1:0] ctrl_q;        // control image
    logic [12:0] depth_q;                   // fifo entries
    logic [12:0] aeth_q;                    // almost empty threshold
    logic [12:0] afth_q;                    // almost full threshold
    logic [3:0]  irq_stat_q;                // sticky events
    logic [3:0]  irq_mask_q;                // event enables
    dpsf_cfg_t   cfg;                       // decoded control
    // fifo state
    logic [11:0] wr_ptr_q;                  // write pointer
    logic [11:0] rd_ptr_q;                  // read pointer
    logic [12:0] cnt_q;                     // stored entries
    logic [12:0] cnt_d;                     // next count
    logic [12:0] eff_depth;                 // clamped depth
    dpsf_flags_t flags_q;                   // registered flags
    // access path
    dpsf_width_t rd_w_eff;                  // read shape in use
    dpsf_loc_t   wloc;                      // write position
    dpsf_loc_t   rloc;                      // read position
    logic        full_now;                  // count at depth
    logic        empty_now;                 // count at zero
    logic        wr_go;                     // write accepted
    logic        rd_go;                     // read accepted
    logic [17:0] rd_raw;                    // array read value
    logic [17:0] out_d;                     // next read port value
    logic [17:0] stage_q;                   // pipeline stage
    logic [17:0] rd_data_q;                 // read port flop
    // apb
    logic        pready_q;                  // access phase ready
    logic [31:0] prdata_q;                  // read data flop
    logic        pslverr_q;                 // unmapped address
    logic        wr_acc;                    // write takes effect
    logic        hit;                       // mapped address
    logic [31:0] rmux;                      // read selection
    logic [3:0]  evt;                       // event pulses
    logic        irq_q;                     // interrupt flop

    assign cfg = dpsf_cfg_t'(ctrl_q);

    // entries a shape holds; the 1, 2 and 4 bit shapes reach 4096 bits, the 9 and 18 bit shapes 4608
    function automatic logic [12:0] cap_of(input dpsf_width_t w);
        case (w)
            WID_1:   cap_of = 13'h1000;
            WID_2:   cap_of = 13'h0800;
            WID_4:   cap_of = 13'h0400;
            WID_18:  cap_of = 13'h0100;
            default: cap_of = 13'h0200;
        endcase
    endfunction : cap_of

    // narrow shapes use bits 0..7 of each word, so one bit
    // address means the same cell for 1, 2 and 4 bit ports
    function automatic dpsf_loc_t locate(input dpsf_width_t w, input logic [11:0] a);
        dpsf_loc_t l;
        l = '0;
        case (w)
            WID_1:   l = '{word: a[11:3], off: a[2:0]};
            WID_2:   l = '{word: a[10:2], off: {a[1:0], 1'b0}};
            WID_4:   l = '{word: a[9:1], off: {a[0], 2'b00}};
            WID_18:  l = '{word: {a[7:0], 1'b0}, off: 3'h0};
            default: l = '{word: a[8:0], off: 3'h0};
        endcase
        return l;
    endfunction : locate

    // bits of a word touched by one narrow access
    function automatic logic [8:0] lane_mask(input dpsf_width_t w, input logic [2:0] off);
        case (w)
            WID_1:   lane_mask = 9'h001 << off;
            WID_2:   lane_mask = 9'h003 << off;
            WID_4:   lane_mask = 9'h00F << off;
            default: lane_mask = 9'h1FF;
        endcase
    endfunction : lane_mask

    // port addressing: fifo mode ignores user addresses
    always_comb
    begin
        rd_w_eff  = cfg.fifo ? cfg.wr_w : cfg.rd_w;
        wloc      = locate(cfg.wr_w, cfg.fifo ? wr_ptr_q : WR_ADDR);
        rloc      = locate(rd_w_eff, cfg.fifo ? rd_ptr_q : RD_ADDR);
        eff_depth = cap_of(cfg.wr_w);
        // zero or oversize depth means the whole array
        if (depth_q != 13'h0 && depth_q < eff_depth)
            eff_depth = depth_q;
        full_now  = cnt_q == eff_depth;
        empty_now = cnt_q == 13'h0;
    end

    // accept rules; select low parks a block of a cascade
    assign wr_go = WR_EN && WR_SEL && !(cfg.fifo && full_now);
    assign rd_go = RD_EN && RD_SEL && !(cfg.fifo && empty_now);

    // array writes; test port load takes priority
    always_ff @(posedge CLOCK)
    begin
        if (TP_LOAD_EN)
        begin
            mem[TP_LOAD_ADDR] <= TP_LOAD_DATA;
        end
        else if (wr_go)
        begin
            if (cfg.wr_w == WID_18)
            begin
                mem[wloc.word] <= WR_DATA[8:0];
                mem[{wloc.word[8:1], 1'b1}] <= WR_DATA[17:9];
            end
            else
            begin
                // read-modify-write of the touched lanes only
                mem[wloc.word] <= (mem[wloc.word] & ~lane_mask(cfg.wr_w, wloc.off))
                                | ((WR_DATA[8:0] << wloc.off) & lane_mask(cfg.wr_w, wloc.off));
            end
        end
    end

    // array read, right-justified to the read shape
    always_comb
    begin
        rd_raw = 18'h0;
        case (rd_w_eff)
            WID_18:  rd_raw = {mem[{rloc.word[8:1], 1'b1}], mem[rloc.word]};
            WID_9:   rd_raw = {9'h0, mem[rloc.word]};
            default: rd_raw = {9'h0, (mem[rloc.word] >> rloc.off) & lane_mask(rd_w_eff, 3'h0)};
        endcase
    end

    // next read port value; a read beats write-through
    always_comb
    begin
        out_d = cfg.pipe ? stage_q : rd_data_q;
        if (rd_go)
            out_d = rd_raw;
        else if (wr_go && cfg.wos)
            out_d = WR_DATA;
    end

    // pipeline stage, cleared by reset; it shadows the port in
    // flow-through so a switch to pipelined keeps the held word
    always_ff @(posedge CLOCK)
    begin
        if (!NRST)
            stage_q <= 18'h0;
        else
            stage_q <= out_d;
    end

    // read port flop: one edge flow-through, two pipelined
    always_ff @(posedge CLOCK)
    begin
        if (!NRST)
            rd_data_q <= 18'h0;
        else if (cfg.pipe)
            rd_data_q <= stage_q;
        else
            rd_data_q <= out_d;
    end

    // pointer counters wrap at the clamped depth
    always_ff @(posedge CLOCK)
    begin
        if (!NRST)
        begin
            wr_ptr_q <= 12'h0;
            rd_ptr_q <= 12'h0;
        end
        else if (cfg.fifo)
        begin
            if (wr_go)
                wr_ptr_q <= ({1'b0, wr_ptr_q} + 13'h1 >= eff_depth) ? 12'h0 : wr_ptr_q + 12'h1;
            if (rd_go)
                rd_ptr_q <= ({1'b0, rd_ptr_q} + 13'h1 >= eff_depth) ? 12'h0 : rd_ptr_q + 12'h1;
        end
    end

    // entry count; stays put on simultaneous read and write
    always_comb
    begin
        cnt_d = cnt_q;
        if (cfg.fifo && wr_go && !rd_go)
            cnt_d = cnt_q + 13'h1;
        else if (cfg.fifo && rd_go && !wr_go)
            cnt_d = cnt_q - 13'h1;
    end

    // count register
    always_ff @(posedge CLOCK)
    begin
        if (!NRST)
            cnt_q <= 13'h0;
        else
            cnt_q <= cnt_d;
    end

    // flags follow the count; thresholds compare inclusively
    always_ff @(posedge CLOCK)
    begin
        if (!NRST)
        begin
            flags_q <= '{af: 1'b0, ae: 1'b1, full: 1'b0, empty: 1'b1};
        end
        else
        begin
            flags_q.empty <= cnt_d == 13'h0;
            flags_q.full  <= cnt_d == eff_depth;
            flags_q.ae    <= cnt_d <= aeth_q;
            flags_q.af    <= cnt_d >= afth_q;
        end
    end

    // events: rising full and empty flags and refused fifo requests
    assign evt[`DPSF_EVT_FULL]  = !flags_q.full && cnt_d == eff_depth;
    assign evt[`DPSF_EVT_EMPTY] = !flags_q.empty && cnt_d == 13'h0;
    assign evt[`DPSF_EVT_OVER]  = cfg.fifo && WR_EN && WR_SEL && full_now;
    assign evt[`DPSF_EVT_UNDER] = cfg.fifo && RD_EN && RD_SEL && empty_now;

    // sticky status, write one to clear; a new event wins
    for (genvar i = 0; i < `DPSF_N_EVT; i++)
    begin : g_irq
        always_ff @(posedge CLOCK)
        begin
            if (!NRST)
                irq_stat_q[i] <= 1'b0;
            else if (evt[i])
                irq_stat_q[i] <= 1'b1;
            else if (wr_acc && PADDR == `DPSF_IRQ_STAT_OFS && PWDATA[i])
                irq_stat_q[i] <= 1'b0;
        end
    end

    // interrupt level, one edge behind the status
    always_ff @(posedge CLOCK)
    begin
        if (!NRST)
            irq_q <= 1'b0;
        else
            irq_q <= |(irq_stat_q & irq_mask_q);
    end

    // apb: one wait-free access phase after every setup
    assign wr_acc = PSEL && PENABLE && pready_q && PWRITE;

    // register read selection and decode
    always_comb
    begin
        hit  = 1'b1;
        rmux = 32'h0;
        case (PADDR)
            `DPSF_CTRL_OFS:     rmux = {23'h0, ctrl_q};
            `DPSF_DEPTH_OFS:    rmux = {19'h0, depth_q};
            `DPSF_AE_OFS:       rmux = {19'h0, aeth_q};
            `DPSF_AF_OFS:       rmux = {19'h0, afth_q};
            `DPSF_STAT_OFS:     rmux = {15'h0, cnt_q, flags_q};
            `DPSF_IRQ_STAT_OFS: rmux = {28'h0, irq_stat_q};
            `DPSF_IRQ_MASK_OFS: rmux = {28'h0, irq_mask_q};
            default:            hit  = 1'b0;
        endcase
    end

    // apb answer flops, loaded during the setup cycle
    always_ff @(posedge CLOCK)
    begin
        if (!NRST)
        begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q  <= PSEL && !PENABLE;
            pslverr_q <= PSEL && !PENABLE && !hit;
            if (PSEL && !PENABLE && !PWRITE)
                prdata_q <= rmux;
        end
    end

    // writable registers; unmapped writes are dropped
    always_ff @(posedge CLOCK)
    begin
        if (!NRST)
        begin
            ctrl_q     <= `DPSF_CTRL_RST;
            depth_q    <= `DPSF_DEPTH_RST;
            aeth_q     <= `DPSF_AE_RST;
            afth_q     <= `DPSF_AF_RST;
            irq_mask_q <= 4'h0;
        end
        else if (wr_acc)
        begin
            case (PADDR)
                `DPSF_CTRL_OFS:     ctrl_q     <= PWDATA[`DPSF_CTRL_W-1:0];
                `DPSF_DEPTH_OFS:    depth_q    <= PWDATA[12:0];
                `DPSF_AE_OFS:       aeth_q     <= PWDATA[12:0];
                `DPSF_AF_OFS:       afth_q     <= PWDATA[12:0];
                `DPSF_IRQ_MASK_OFS: irq_mask_q <= PWDATA[3:0];
                default:            ;
            endcase
        end
    end

    // outputs, all straight from flops
    assign PRDATA       = prdata_q;
    assign PREADY       = pready_q;
    assign PSLVERR      = pslverr_q;
    assign RD_DATA      = rd_data_q;
    assign EMPTY        = flags_q.empty;
    assign FULL         = flags_q.full;
    assign ALMOST_EMPTY = flags_q.ae;
    assign ALMOST_FULL  = flags_q.af;
    assign IRQ          = irq_q;

    // checks
    chk_reset_clears: assert property (@(posedge CLOCK) disable iff (!NRST)
        $rose(NRST) |-> RD_DATA == 18'h0)
        else $error("read data not zero after reset");

    chk_full_ignore: assert property (@(posedge CLOCK) disable iff (!NRST)
        (cfg.fifo && full_now && WR_EN && WR_SEL) |=> $stable(wr_ptr_q))
        else $error("write pointer moved while full");

    chk_empty_ignore: assert property (@(posedge CLOCK) disable iff (!NRST)
        (cfg.fifo && empty_now && RD_EN && RD_SEL && !wr_go) |=> $stable(rd_ptr_q) && cnt_q == 13'h0)
        else $error("read accepted while empty");

    chk_count_step: assert property (@(posedge CLOCK) disable iff (!NRST)
        (cfg.fifo && wr_go && !rd_go) |=> cnt_q == $past(cnt_q) + 13'h1)
        else $error("count did not rise on write");

    chk_empty_flag: assert property (@(posedge CLOCK) disable iff (!NRST)
        EMPTY == (cnt_q == 13'h0) && FULL == (cnt_q == $past(eff_depth)))
        else $error("empty or full flag wrong");

    chk_ae_thresh: assert property (@(posedge CLOCK) disable iff (!NRST)
        $stable(aeth_q) |-> ALMOST_EMPTY == (cnt_q <= aeth_q))
        else $error("almost empty flag wrong");

    chk_af_thresh: assert property (@(posedge CLOCK) disable iff (!NRST)
        $stable(afth_q) |-> ALMOST_FULL == (cnt_q >= afth_q))
        else $error("almost full flag wrong");

    chk_flow_read: assert property (@(posedge CLOCK) disable iff (!NRST)
        (rd_go && !cfg.pipe) |=> RD_DATA == $past(rd_raw))
        else $error("flow-through read late or wrong");

    chk_pipe_read: assert property (@(posedge CLOCK) disable iff (!NRST)
        (rd_go && cfg.pipe) ##1 cfg.pipe |=> RD_DATA == $past(rd_raw, 2))
        else $error("pipelined read late or wrong");

    chk_write_hold: assert property (@(posedge CLOCK) disable iff (!NRST)
        (wr_go && !rd_go && !cfg.wos && !cfg.pipe) |=> $stable(RD_DATA))
        else $error("read data changed during write");

    chk_write_show: assert property (@(posedge CLOCK) disable iff (!NRST)
        (wr_go && !rd_go && cfg.wos && !cfg.pipe) |=> RD_DATA == $past(WR_DATA))
        else $error("write data not shown");

endmodule : dpsf_top

// file: verif/dpsf_user.sv
// user-logic model on the fabric side of the sram/fifo block: write, read, preload
// assumes every task is entered right after a rising edge of CLOCK
`timescale 1ns/1ps
module dpsf_user (
    input  wire logic        CLOCK,
    output logic             WR_SEL,
    output logic             WR_EN,
    output logic      [11:0] WR_ADDR,
    output logic      [17:0] WR_DATA,
    output logic             RD_SEL,
    output logic             RD_EN,
    output logic      [11:0] RD_ADDR,
    output logic             TP_LOAD_EN,
    output logic      [8:0]  TP_LOAD_ADDR,
    output logic      [8:0]  TP_LOAD_DATA
);
    // quiet, selected ports at time zero
    initial
    begin
        {WR_EN, RD_EN, TP_LOAD_EN}   = 3'h0;
        {WR_SEL, RD_SEL}             = 2'h3;
        {WR_ADDR, RD_ADDR}           = 24'h0;
        WR_DATA                      = 18'h0;
        {TP_LOAD_ADDR, TP_LOAD_DATA} = 18'h0;
    end
    // one write beat; the request stays up until stop or the next call
    task automatic wr(input logic s, input logic [11:0] a, input logic [17:0] d);
        RD_EN   <= 1'b0;
        WR_SEL  <= s;
        WR_EN   <= 1'b1;
        WR_ADDR <= a;
        WR_DATA <= d;
        @(posedge CLOCK);
    endtask : wr
    // one read beat; in fifo mode the address is a don't-care
    task automatic rd(input logic [11:0] a);
        WR_EN   <= 1'b0;
        RD_EN   <= 1'b1;
        RD_ADDR <= a;
        @(posedge CLOCK);
    endtask : rd
    // read beat with this block deselected, as a cascade neighbour sees it
    task automatic rd_off(input logic [11:0] a);
        RD_SEL <= 1'b0;
        rd(a);
        RD_SEL <= 1'b1;
    endtask : rd_off
    // release both ports; stale write data and read address are inverted so they never pass for fresh
    task automatic stop;
        WR_EN   <= 1'b0;
        RD_EN   <= 1'b0;
        WR_SEL  <= 1'b1;
        WR_DATA <= ~WR_DATA;
        RD_ADDR <= ~RD_ADDR;
        @(posedge CLOCK);
    endtask : stop
    // preload one array word through the test port
    task automatic tp(input logic [8:0] a, input logic [8:0] d);
        TP_LOAD_EN   <= 1'b1;
        TP_LOAD_ADDR <= a;
        TP_LOAD_DATA <= d;
        @(posedge CLOCK);
        TP_LOAD_EN   <= 1'b0;
        TP_LOAD_DATA <= ~d;
    endtask : tp
endmodule : dpsf_user

// file: verif/tb.sv
// self-checking bench for the sram/fifo block: apb setup plus user-port traffic
// assumes dpsf_user drives the user ports; outputs sampled at the edge after they settle
`timescale 1ns/1ps
`include "dpsf_regs.svh"
module tb
    import dpsf_pkg::*;
;
    logic        CLOCK;                // 125 MHz
    logic        NRST;                 // sync reset, active low
    logic        PSEL;                 // apb select
    logic        PENABLE;              // apb access phase
    logic        PWRITE;               // apb direction
    logic [11:0] PADDR;                // apb byte address
    logic [31:0] PWDATA;               // apb write data
    logic [31:0] PRDATA;               // apb read data
    logic        PREADY;               // apb ready
    logic        PSLVERR;              // apb error
    logic        WR_SEL, WR_EN, RD_SEL, RD_EN, TP_LOAD_EN;
    logic [11:0] WR_ADDR, RD_ADDR;     // port addresses
    logic [17:0] WR_DATA, RD_DATA;     // port data
    logic [8:0]  TP_LOAD_ADDR, TP_LOAD_DATA;
    logic        EMPTY, FULL, ALMOST_EMPTY, ALMOST_FULL, IRQ;
    int          fail_count;           // mismatches
    int          n_tests;              // comparisons
    logic [31:0] q;                    // last apb read data
    logic        err;                  // last apb error flag
    wire  [31:0] flags_w = {28'h0, ALMOST_FULL, ALMOST_EMPTY, FULL, EMPTY};
    wire  [31:0] rd_w    = {14'h0, RD_DATA};

    dpsf_top dpsf_top_i (.CLOCK(CLOCK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .WR_SEL(WR_SEL), .WR_EN(WR_EN), .WR_ADDR(WR_ADDR),
        .WR_DATA(WR_DATA), .RD_SEL(RD_SEL), .RD_EN(RD_EN), .RD_ADDR(RD_ADDR),
        .RD_DATA(RD_DATA), .TP_LOAD_EN(TP_LOAD_EN), .TP_LOAD_ADDR(TP_LOAD_ADDR),
        .TP_LOAD_DATA(TP_LOAD_DATA), .EMPTY(EMPTY), .FULL(FULL),
        .ALMOST_EMPTY(ALMOST_EMPTY), .ALMOST_FULL(ALMOST_FULL), .IRQ(IRQ));
    dpsf_user user_i (.CLOCK(CLOCK), .WR_SEL(WR_SEL), .WR_EN(WR_EN), .WR_ADDR(WR_ADDR),
        .WR_DATA(WR_DATA), .RD_SEL(RD_SEL), .RD_EN(RD_EN), .RD_ADDR(RD_ADDR),
        .TP_LOAD_EN(TP_LOAD_EN), .TP_LOAD_ADDR(TP_LOAD_ADDR), .TP_LOAD_DATA(TP_LOAD_DATA));

    // free-running clock, 8 ns period
    initial
    begin
        CLOCK = 1'b0;
        forever #4 CLOCK = ~CLOCK;
    end
    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h, want %h", $time, seen, exp);
        end
    endtask : chk
    // one apb transfer; an idle edge follows so the next setup never collides
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        PSEL    <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE  <= w;
        PADDR   <= a;
        PWDATA  <= d;
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        do
            @(posedge CLOCK);
        while (PREADY !== 1'b1);
        q = PRDATA;
        err = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge CLOCK);
    endtask : apb
    // flag image expected for a fifo of depth 4, thresholds 1 and 3
    function automatic logic [31:0] fl(input int c);
        return {28'h0, c >= 3, c <= 1, c == 4, c == 0};
    endfunction : fl
    // verdict, the single exit
    task automatic end_sim;
        if (fail_count == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_sim
    // hang guard, far beyond the roughly 140 cycles the tests need
    initial
    begin
        repeat (6000) @(posedge CLOCK);
        fail_count++;
        end_sim();
    end

    // main sequence
    initial
    begin
        {NRST, PSEL, PENABLE, PWRITE} = 4'h0;
        PADDR = 12'h000;
        PWDATA = 32'h0;
        fail_count = 0;
        n_tests = 0;
        repeat (20) @(posedge CLOCK);
        chk(rd_w, 32'h0);
        chk(flags_w, 32'h5);
        NRST <= 1'b1;
        apb(1'b0, `DPSF_AE_OFS, 32'h0);
        chk(q, 32'h4);
        apb(1'b0, 12'h01C, 32'h0);
        chk({q[30:0], err}, 32'h1);
        // ram 9/9: deselected write is dropped, so a cascade neighbour keeps its word
        user_i.wr(1'b1, 12'd7, 18'h1A5);
        user_i.wr(1'b0, 12'd7, 18'h0F0);
        user_i.rd(12'd7);
        user_i.stop();
        chk(rd_w, 32'h1A5);
        user_i.wr(1'b1, 12'd8, 18'h055);
        user_i.stop();
        chk(rd_w, 32'h1A5);
        apb(1'b1, `DPSF_CTRL_OFS, 32'h136);
        user_i.wr(1'b1, 12'd9, 18'h0AA);
        user_i.stop();
        chk(rd_w, 32'h0AA);
        user_i.tp(9'd20, 9'h133);
        user_i.rd(12'd20);
        user_i.stop();
        chk(rd_w, 32'h133);
        // pipelined: old word for one more edge
        apb(1'b1, `DPSF_CTRL_OFS, 32'h0B6);
        user_i.rd(12'd7);
        user_i.stop();
        chk(rd_w, 32'h133);
        @(posedge CLOCK);
        chk(rd_w, 32'h1A5);
        // write 4 bits, read back bit by bit, lsb first
        apb(1'b1, `DPSF_CTRL_OFS, 32'h004);
        user_i.wr(1'b1, 12'd3, 18'h00A);
        for (int k = 0; k < 4; k++)
        begin
            user_i.rd(12'(12 + k));
            user_i.stop();
            chk(rd_w, 32'((4'hA >> k) & 4'h1));
        end
        // 2-bit writes gathered by one 4-bit read
        apb(1'b1, `DPSF_CTRL_OFS, 32'h022);
        user_i.wr(1'b1, 12'd2, 18'h001);
        user_i.wr(1'b1, 12'd3, 18'h003);
        user_i.rd(12'd1);
        user_i.stop();
        chk(rd_w, 32'h00D);
        // 18-bit write into the top of the array, 9-bit read of both halves
        apb(1'b1, `DPSF_CTRL_OFS, 32'h038);
        user_i.wr(1'b1, 12'd255, 18'h25A5B);
        user_i.rd(12'd510);
        user_i.stop();
        chk(rd_w, 32'h05B);
        user_i.rd(12'd511);
        user_i.stop();
        chk(rd_w, 32'h12D);
        // reset in mid-run clears the output and the setup
        NRST <= 1'b0;
        @(posedge CLOCK);
        NRST <= 1'b1;
        @(posedge CLOCK);
        chk(rd_w, 32'h0);
        apb(1'b0, `DPSF_CTRL_OFS, 32'h0);
        chk(q, 32'h036);
        // fifo, 9 bits, depth 4, thresholds 1 and 3
        apb(1'b1, `DPSF_DEPTH_OFS, 32'h4);                 
        apb(1'b1, `DPSF_AE_OFS, 32'h1);
        apb(1'b1, `DPSF_AF_OFS, 32'h3);
        apb(1'b1, `DPSF_IRQ_MASK_OFS, 32'hF);
        apb(1'b1, `DPSF_CTRL_OFS, 32'h037);
        apb(1'b1, `DPSF_IRQ_STAT_OFS, 32'hF);
        for (int i = 0; i < 5; i++)
        begin
            user_i.wr(1'b1, 12'hFFF, 18'(18'h100 + i));
            user_i.stop();
            chk(flags_w, fl(i < 4 ? i + 1 : 4));
        end
        apb(1'b0, `DPSF_STAT_OFS, 32'h0);
        chk(q, 32'h4A);
        apb(1'b0, `DPSF_IRQ_STAT_OFS, 32'h0);
        chk({q[30:0], IRQ}, 32'hB);
        apb(1'b1, `DPSF_IRQ_MASK_OFS, 32'h0);
        @(posedge CLOCK);
        chk({31'h0, IRQ}, 32'h0);
        apb(1'b1, `DPSF_IRQ_MASK_OFS, 32'hF);
        apb(1'b1, `DPSF_IRQ_STAT_OFS, 32'h5);
        @(posedge CLOCK);
        chk({31'h0, IRQ}, 32'h0);
        // deselected read pops nothing and leaves the port alone
        user_i.rd_off(12'h000);
        user_i.stop();
        chk(flags_w, fl(4));
        chk(rd_w, 32'h0);
        // drain past empty: order kept, the extra read only sets the underflow status bit
        for (int i = 0; i < 5; i++)
        begin
            user_i.rd(12'h000);
            user_i.stop();
            chk(flags_w, fl(i < 4 ? 3 - i : 0));
            chk(rd_w, 32'(32'h100 + (i < 4 ? i : 3)));
        end
        apb(1'b0, `DPSF_IRQ_STAT_OFS, 32'h0);
        chk({q[30:0], IRQ}, 32'h15);
        apb(1'b1, `DPSF_IRQ_STAT_OFS, 32'hA);
        @(posedge CLOCK);
        chk({31'h0, IRQ}, 32'h0);
        end_sim();
    end
endmodule : tb
